// ### src/dsd_consts.vh
// constants for the divide and shift datapath
`ifndef DSD_CONSTS_VH
`define DSD_CONSTS_VH
`define DSD_WORD_W      16
`define DSD_DWORD_W     32
`define DSD_REG_IDX_W   4
`define DSD_SHAMT_W     4
`define DSD_DIV_STEPS   5'h10
`define DSD_CNT_W       5
`define DSD_SH_ASR      2'h0
`define DSD_SH_LSR      2'h1
`define DSD_SH_SL       2'h2
`define DSD_QUOT_REG    4'h0
`define DSD_REM_REG     4'h1
`define DSD_ZERO_WORD   16'h0000
`define DSD_ONES_WORD   16'hFFFF
`endif

// ### src/dsd_shifter.v
// single-cycle barrel shifter for the datapath
`timescale 1ns/10ps
`include "dsd_consts.vh"
module dsd_shifter #(
    parameter W   = 16,
    parameter SAW = 4
) (
    input  wire [W-1:0]   operand_i,
    input  wire [SAW-1:0] amount_i,
    input  wire [1:0]     op_i,
    output reg  [W-1:0]   result_o
);
    wire signed [W-1:0] sop;
    assign sop = operand_i;

    always @* begin
        case (op_i)
            `DSD_SH_ASR: result_o = sop >>> amount_i;
            `DSD_SH_LSR: result_o = operand_i >> amount_i;
            `DSD_SH_SL:  result_o = operand_i << amount_i;
            default:     result_o = operand_i;
        endcase
    end
endmodule

// ### src/dsd_datapath.v
// divide and multi-bit shift datapath with its working register file
`timescale 1ns/10ps
`include "dsd_consts.vh"
// Behaviour
// - the divider handles 32/16 and 16/16 division, each signed or unsigned.
// - every divide writes its quotient to working register zero and remainder to working register one.
// - any register may hold the divisor, and any even/odd pair the 32-bit dividend with the odd one high.
// - the divide takes one cycle per divisor bit, so both sizes take the same sixteen step cycles plus one write-back cycle.
// - single and multi-bit shifts both exist and every multi-bit shift takes one cycle.
// - the shifter moves right arithmetically or left by up to fifteen places in one cycle.
// - shifts read a working register and write a working register, with no memory modes.
// - arithmetic right shift fills vacated upper bits with the original sign bit.
// - logical right shift fills vacated upper bits with zeros.
// - left shift fills vacated low bits with zeros.
module dsd_datapath #(
    parameter W   = 16,
    parameter NR  = 16
) (
    input  wire         clk_i,
    input  wire         arst_n_i,
    input  wire         wr_en_i,
    input  wire [3:0]   wr_idx_i,
    input  wire [W-1:0] wr_data_i,
    input  wire [3:0]   rd_idx_i,
    output reg  [W-1:0] rd_data_o,
    input  wire         shift_start_i,
    input  wire [1:0]   shift_op_i,
    input  wire [3:0]   shift_src_i,
    input  wire [3:0]   shift_dst_i,
    input  wire [3:0]   shift_amt_i,
    input  wire         div_start_i,
    input  wire         div_signed_i,
    input  wire         div_long_i,
    input  wire [3:0]   div_dividend_i,
    input  wire [3:0]   divisor_source_register_i,
    output wire         busy_o,
    output reg          done_o,
    output reg          div_by_zero_o
);
    localparam ST_IDLE = 2'b01;
    localparam ST_DIV  = 2'b10;

    reg [W-1:0]  regs [0:NR-1];
    reg [1:0]    state;
    reg [`DSD_CNT_W-1:0] count;
    reg [2*W-1:0] rem_quo;
    reg [W-1:0]  dvsr;
    reg          neg_q;
    reg          neg_r;
    reg          zero_div;
    wire [W-1:0] shift_res;
    wire [W:0]   trial;
    wire [2*W-1:0] shifted;
    wire [W-1:0] quo_mag;
    wire [W-1:0] rem_mag;
    wire [W-1:0] quo_out;
    wire [W-1:0] rem_out;
    wire [3:0]   even_idx;
    wire [2*W-1:0] dividend_raw;
    wire [2*W-1:0] dividend_mag;
    wire [W-1:0] divisor_raw;
    wire         dividend_neg;
    wire         divisor_neg;
    wire         idle;
    wire         divisor_zero;
    wire [W-1:0] divisor_mag;
    wire [W-1:0] mod_base;
    wire [W-1:0] upper_rem;
    wire         step_take;
    wire         count_zero;
    wire         div_take;
    wire         shift_take;
    wire         wr_take;
    reg  [W-1:0] dividend_raw_low;
    reg  [W-1:0] quo_final;
    reg  [W-1:0] rem_final;
    reg  [1:0]   next_state;
    reg  [`DSD_CNT_W-1:0] next_count;
    integer      i;

    assign idle = state[0];
    assign busy_o = ~idle;
    assign even_idx = {div_dividend_i[3:1], 1'b0};
    // odd register of the pair is the upper half
    assign dividend_raw = div_long_i ? {regs[even_idx | 4'h1], regs[even_idx]}
                        : (div_signed_i ? {{W{regs[div_dividend_i][W-1]}}, regs[div_dividend_i]}
                                        : {{W{1'b0}}, regs[div_dividend_i]});
    assign divisor_raw  = regs[divisor_source_register_i];
    assign dividend_neg = div_signed_i & dividend_raw[2*W-1];
    assign divisor_neg  = div_signed_i & divisor_raw[W-1];
    assign dividend_mag = dividend_neg ? (~dividend_raw + 1'b1) : dividend_raw;
    assign divisor_zero = (divisor_raw == `DSD_ZERO_WORD);
    assign divisor_mag  = divisor_neg ? (~divisor_raw + 1'b1) : divisor_raw;

    // upper half is pre-reduced to a partial remainder so sixteen steps suffice;
    // a quotient wider than sixteen bits keeps only its low word
    assign mod_base  = divisor_zero ? {{W-1{1'b0}}, 1'b1} : divisor_mag;
    assign upper_rem = dividend_mag[2*W-1:W] % mod_base;

    // requests only while idle: divide before shift before write
    assign div_take   = idle & div_start_i;
    assign shift_take = idle & ~div_start_i & shift_start_i;
    assign wr_take    = idle & ~div_start_i & ~shift_start_i & wr_en_i;

    // restoring step: one quotient bit per cycle
    assign shifted = {rem_quo[2*W-2:0], 1'b0};
    assign trial   = {rem_quo[2*W-1], shifted[2*W-1:W]} - {1'b0, dvsr};
    assign quo_mag = rem_quo[W-1:0];
    assign rem_mag = rem_quo[2*W-1:W];
    assign step_take  = ~trial[W];
    assign count_zero = (count == {`DSD_CNT_W{1'b0}});
    // magnitudes truncate toward zero; signs are reapplied afterwards
    assign quo_out = neg_q ? (~quo_mag + 1'b1) : quo_mag;
    assign rem_out = neg_r ? (~rem_mag + 1'b1) : rem_mag;

    // zero divisor answer: quotient all ones, remainder the low dividend word
    always @* begin
        if (zero_div) begin
            quo_final = `DSD_ONES_WORD;
            rem_final = dividend_raw_low;
        end else begin
            quo_final = quo_out;
            rem_final = rem_out;
        end
    end

    dsd_shifter #(
        .W   (W),
        .SAW (`DSD_SHAMT_W)
    ) u_shifter (
        .operand_i (regs[shift_src_i]),
        .amount_i  (shift_amt_i),
        .op_i      (shift_op_i),
        .result_o  (shift_res)
    );

    always @* begin
        rd_data_o = regs[rd_idx_i];
    end

    // bit loop sequencing: sixteen steps, then one cycle to write back
    always @* begin
        next_state = state;
        next_count = count;
        case (state)
            ST_IDLE: begin
                if (div_take) begin
                    next_state = ST_DIV;
                    next_count = `DSD_DIV_STEPS;
                end
            end
            ST_DIV: begin
                if (count_zero) begin
                    next_state = ST_IDLE;
                end else begin
                    next_count = count - 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_count = {`DSD_CNT_W{1'b0}};
            end
        endcase
    end

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state         <= ST_IDLE;
            count         <= {`DSD_CNT_W{1'b0}};
            rem_quo       <= {2*W{1'b0}};
            dvsr          <= `DSD_ZERO_WORD;
            neg_q         <= 1'b0;
            neg_r         <= 1'b0;
            zero_div      <= 1'b0;
            done_o        <= 1'b0;
            div_by_zero_o <= 1'b0;
            for (i = 0; i < NR; i = i + 1) begin
                regs[i] <= `DSD_ZERO_WORD;
            end
        end else begin
            state  <= next_state;
            count  <= next_count;
            done_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (div_take) begin
                        rem_quo  <= {upper_rem, dividend_mag[W-1:0]};
                        dvsr     <= divisor_mag;
                        neg_q    <= dividend_neg ^ divisor_neg;
                        neg_r    <= dividend_neg;
                        zero_div <= divisor_zero;
                    end else if (shift_take) begin
                        regs[shift_dst_i] <= shift_res;
                        done_o <= 1'b1;
                    end else if (wr_take) begin
                        regs[wr_idx_i] <= wr_data_i;
                    end
                end
                ST_DIV: begin
                    if (!count_zero) begin
                        if (step_take) begin
                            rem_quo <= {trial[W-1:0], shifted[W-1:1], 1'b1};
                        end else begin
                            rem_quo <= shifted;
                        end
                    end else begin
                        regs[`DSD_QUOT_REG] <= quo_final;
                        regs[`DSD_REM_REG]  <= rem_final;
                        div_by_zero_o <= zero_div;
                        done_o <= 1'b1;
                    end
                end
                default: rem_quo <= {2*W{1'b0}};
            endcase
        end
    end

    // low dividend word captured at start for the zero divisor answer
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dividend_raw_low <= `DSD_ZERO_WORD;
        end else if (div_take) begin
            dividend_raw_low <= dividend_raw[W-1:0];
        end
    end
endmodule

// ### bench/dsd_datapath_props.sv
// timing assertions for the divide and shift datapath
`timescale 1ns/10ps
module dsd_datapath_props (
    input wire clk_i,
    input wire arst_n_i,
    input wire div_start_i,
    input wire shift_start_i,
    input wire busy_o,
    input wire done_o,
    input wire div_by_zero_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    property p_take; div_start_i && !busy_o |=> busy_o; endproperty
    property p_len; $rose(busy_o) |-> ##16 busy_o ##1 !busy_o; endproperty
    property p_end; $fell(busy_o) |-> done_o; endproperty
    property p_cause; done_o |-> $past(shift_start_i) || $fell(busy_o); endproperty
    property p_shift; shift_start_i && !busy_o && !div_start_i |=> done_o && !busy_o; endproperty
    property p_rise; $rose(busy_o) |-> $past(div_start_i); endproperty
    // flag may only move when a divide result lands
    property p_flag; $changed(div_by_zero_o) |-> $fell(busy_o); endproperty
    property p_quiet; busy_o |-> !done_o; endproperty
    a_take: assert property (p_take) else $error("divide start not taken");
    a_len: assert property (p_len) else $error("divide length wrong");
    a_end: assert property (p_end) else $error("no done at divide end");
    a_cause: assert property (p_cause) else $error("done without cause");
    a_shift: assert property (p_shift) else $error("shift not single cycle");
    a_rise: assert property (p_rise) else $error("busy without start");
    a_flag: assert property (p_flag) else $error("zero flag moved mid run");
    a_quiet: assert property (p_quiet) else $error("done while busy");
    c_zero: cover property ($fell(busy_o) && div_by_zero_o);
    c_div: cover property ($fell(busy_o) && !div_by_zero_o);
    c_shift: cover property (shift_start_i && !busy_o ##1 done_o);
endmodule
bind dsd_datapath dsd_datapath_props i_dsd_datapath_props (.clk_i, .arst_n_i, .div_start_i,
    .shift_start_i, .busy_o, .done_o, .div_by_zero_o);

// ### bench/dsd_core_model.sv
// decode and issue model that feeds the datapath
`timescale 1ns/10ps
module dsd_core_model (
    input  wire        clk_i,
    output reg         we_o,
    output reg  [3:0]  wi_o,
    output reg  [15:0] wd_o,
    output reg  [3:0]  ri_o,
    output reg         ss_o,
    output reg  [1:0]  so_o,
    output reg  [3:0]  sr_o,
    output reg  [3:0]  sd_o,
    output reg  [3:0]  sa_o,
    output reg         ds_o,
    output reg         dg_o,
    output reg         dl_o,
    output reg  [3:0]  dd_o,
    output reg  [3:0]  dv_o
);
    initial {we_o, wi_o, wd_o, ri_o, ss_o, so_o, sr_o, sd_o, sa_o, ds_o, dg_o, dl_o, dd_o, dv_o} = '0;
    // data inverted once the strobe drops, so a stale bus is never trusted
    task wr(input [3:0] i, input [15:0] d);
        @(negedge clk_i) {we_o, wi_o, wd_o} = {1'b1, i, d};
        @(negedge clk_i) {we_o, wd_o} = {1'b0, ~d};
    endtask
    task shift(input [1:0] op, input [3:0] s, input [3:0] t, input [3:0] a);
        @(negedge clk_i) {ss_o, so_o, sr_o, sd_o, sa_o} = {1'b1, op, s, t, a};
        @(negedge clk_i) ss_o = 1'b0;
    endtask
    task div(input sg, input lg, input [3:0] n, input [3:0] v);
        @(negedge clk_i) {ds_o, dg_o, dl_o, dd_o, dv_o} = {1'b1, sg, lg, n, v};
        @(negedge clk_i) ds_o = 1'b0;
    endtask
    task sel(input [3:0] i);
        @(negedge clk_i) ri_o = i;
    endtask
endmodule

// ### bench/dsd_datapath_tb_top.sv
// self-checking bench for the divide and shift datapath
`timescale 1ns/10ps
module dsd_datapath_tb_top;
    reg         clk_i = 1'b0;
    reg         arst_n_i = 1'b0;
    wire        we_o, ss_o, ds_o, dg_o, dl_o, busy, done, dbz;
    wire [1:0]  so_o;
    wire [3:0]  wi_o, ri_o, sr_o, sd_o, sa_o, dd_o, dv_o;
    wire [15:0] wd_o, rd;
    integer     bad_count = 0;
    integer     compares = 0;
    initial forever #50 clk_i = ~clk_i;
    dsd_core_model i_dsd_core_model (.clk_i, .we_o, .wi_o, .wd_o, .ri_o, .ss_o, .so_o, .sr_o, .sd_o,
        .sa_o, .ds_o, .dg_o, .dl_o, .dd_o, .dv_o);
    dsd_datapath i_dsd_datapath (.clk_i, .arst_n_i, .wr_en_i(we_o), .wr_idx_i(wi_o), .wr_data_i(wd_o),
        .rd_idx_i(ri_o), .rd_data_o(rd), .shift_start_i(ss_o), .shift_op_i(so_o), .shift_src_i(sr_o),
        .shift_dst_i(sd_o), .shift_amt_i(sa_o), .div_start_i(ds_o), .div_signed_i(dg_o),
        .div_long_i(dl_o), .div_dividend_i(dd_o), .divisor_source_register_i(dv_o), .busy_o(busy),
        .done_o(done), .div_by_zero_o(dbz));
    task chk(input string n, input [15:0] e, input [15:0] s);
        compares = compares + 1;
        if (s !== e) begin
            bad_count = bad_count + 1;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task getr(input [3:0] i, input [15:0] e);
        i_dsd_core_model.sel(i);
        #1 chk("register", e, rd);
    endtask
    task t_shift;
        reg [15:0] x;
        reg [15:0] e;
        integer op;
        integer k;
        x = 16'h93c5;
        i_dsd_core_model.wr(4'h5, x);
        for (op = 0; op < 4; op = op + 1) begin
            for (k = 1; k < 16; k = k + 14) begin
                e = op == 0 ? {{16{x[15]}}, x} >> k : op == 1 ? x >> k : op == 2 ? x << k : x;
                i_dsd_core_model.shift(op[1:0], 4'h5, op[3:0] + 4'ha, k[3:0]);
                chk("done", 16'h0001, {15'h0000, done});
                getr(op[3:0] + 4'ha, e);
            end
        end
        $display("shift test done");
    endtask
    task t_div(input sg, input lg, input [31:0] n, input [15:0] d);
        reg [31:0] q;
        reg [31:0] r;
        reg [31:0] dx;
        integer c;
        i_dsd_core_model.wr(4'h6, n[15:0]);
        i_dsd_core_model.wr(4'h7, n[31:16]);
        i_dsd_core_model.wr(4'h9, d);
        if (!lg) n[31:16] = sg ? {16{n[15]}} : 16'h0000;
        dx = {{16{d[15]}}, d};
        if (d == 16'h0000) {q, r} = {32'h0000_ffff, n};
        else if (sg) {q, r} = {$signed(n) / $signed(dx), $signed(n) % $signed(dx)};
        else {q, r} = {n / d, n % d};
        i_dsd_core_model.div(sg, lg, lg ? 4'h7 : 4'h6, 4'h9);
        chk("busy", 16'h0001, {15'h0000, busy});
        c = 0;
        while (done !== 1'b1 && c < 40) @(negedge clk_i) c = c + 1;
        chk("cycles", 16'h0011, c[15:0]);
        chk("zero flag", {15'h0000, d == 16'h0000}, {15'h0000, dbz});
        getr(4'h0, q[15:0]);
        getr(4'h1, r[15:0]);
        $display("divide test done");
    endtask
    task close_out;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #2000000;
        bad_count = bad_count + 1;
        close_out;
    end
    initial begin
        repeat (12) @(posedge clk_i);
        @(negedge clk_i) arst_n_i = 1'b1;
        t_shift;
        t_div(1'b0, 1'b0, 32'h5a5a_03e8, 16'h0007);
        t_div(1'b1, 1'b0, 32'h1234_fff9, 16'h0002);
        t_div(1'b1, 1'b0, 32'h0000_0064, 16'hfff9);
        t_div(1'b0, 1'b1, 32'h0001_0000, 16'h0010);
        t_div(1'b1, 1'b1, 32'hfffe_7960, 16'h0007);
        t_div(1'b0, 1'b0, 32'h0000_1234, 16'h0000);
        close_out;
    end
endmodule
